/* File: lsrc_pkg.sv */
// Constants and types for the LED sink control register bank
package lsrc_pkg;
    // Register offsets
    localparam logic [7:0] DARK_DIM_CURRENT_OFFS = 8'h0e;
    localparam logic [7:0] SINK_FADE_LAW_CTRL_OFFS = 8'h0f;
    localparam logic [7:0] SINK_ENABLE_CTRL_OFFS = 8'h10;
    localparam logic [7:0] SINK_TIMING_UPPER_OFFS = 8'h11;
    // Field positions and writable masks
    localparam int DARK_DIM_CODE_LSB = 0;
    localparam logic [7:0] DARK_DIM_MASK = 8'h7f;
    localparam int SINK_FADE_LAW_LSB = 0;
    localparam logic [7:0] SINK_FADE_LAW_MASK = 8'h03;
    localparam logic [7:0] SINK_ENABLE_MASK = 8'h7f;
    localparam int SINK_ON_TIME_LSB = 6;
    localparam int SINK7_OFF_TIME_LSB = 4;
    localparam int SINK6_OFF_TIME_LSB = 2;
    localparam int SINK5_OFF_TIME_LSB = 0;
    // Reset values
    localparam logic [6:0] DARK_DIM_RESET = 7'h00;
    localparam logic [1:0] SINK_FADE_LAW_RESET = 2'h0;
    localparam logic [6:0] SINK_ENABLE_RESET = 7'h00;
    localparam logic [7:0] SINK_TIMING_RESET = 8'h00;
    // Fade law codes
    localparam logic [1:0] LAW_LINEAR = 2'h0;
    localparam logic [1:0] LAW_SQUARE = 2'h1;
    localparam logic [1:0] LAW_CUBIC_A = 2'h2;
    localparam logic [1:0] LAW_CUBIC_B = 2'h3;
    // Dim current mapping, in microamps
    localparam logic [6:0] DIM_CODE_FULL = 7'h7f;
    localparam logic [14:0] DIM_FULL_UA = 15'h7530;
    localparam logic [14:0] DIM_LIN_STEP_UA = 15'h00ec;
    localparam logic [31:0] DIM_FULL_SQ = 32'h0000_3f01;
    // Blink timing: all times are whole tenths of a second
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 100_000_000;
    localparam int TICK_CYCLES_DOC = TICK_NS / CLK_PERIOD_NS;
    localparam int PRESC_W = 24;
    localparam int TICK_CNT_W = 5;
    localparam logic [4:0] ON_TICKS_0 = 5'h02;
    localparam logic [4:0] ON_TICKS_1 = 5'h06;
    localparam logic [4:0] ON_TICKS_2 = 5'h08;
    localparam logic [4:0] ON_TICKS_3 = 5'h0c;
    localparam logic [4:0] OFF_TICKS_1 = 5'h06;
    localparam logic [4:0] OFF_TICKS_2 = 5'h0c;
    localparam logic [4:0] OFF_TICKS_3 = 5'h12;
    localparam int NUM_SINKS = 7;

    typedef enum logic [1:0] {
        PH_ON = 2'b01,
        PH_OFF = 2'b10
    } lsrc_phase_t;
endpackage

/* File: lsrc_regs.sv */
// LED sink control registers with blink timing and dark dim current selection
`timescale 1ns/100ps
module lsrc_regs
    import lsrc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DOC
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Register access port
    input wire logic wr_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // Backlight selection
    input wire logic dim_timeout_i,
    input wire logic force_dim_i,
    input wire logic bl_square_law_i,
    input wire logic [6:0] bright_code_i,
    output logic [6:0] bl_code_o,
    output logic [14:0] dim_current_ua_o,
    output logic dimmed_o,
    // Off times of sinks 4 to 1, two bits each, sink 4 on top
    input wire logic [7:0] sink_lower_off_i,
    // Sink drive and fade law decode
    output logic [6:0] sink_on_o,
    output logic [1:0] sink_fade_law_o,
    output logic fade_square_dac_o,
    output logic fade_nonlinear_time_o,
    output logic fade_cubic_alt_o
);
    typedef struct packed {
        logic [6:0] dark_dim_code;
        logic [1:0] sink_fade_law;
        logic [6:0] sink_enable;
        logic [7:0] timing;
        logic [PRESC_W-1:0] presc;
        lsrc_phase_t [NUM_SINKS-1:0] phase;
        logic [NUM_SINKS-1:0][TICK_CNT_W-1:0] cnt;
        logic [6:0] sink_on;
        logic [7:0] rdata;
        logic [6:0] bl_code;
        logic [14:0] dim_ua;
        logic dimmed;
        logic square_dac;
        logic nonlin_time;
        logic cubic_alt;
    } lsrc_state_t;

    lsrc_state_t cur;
    lsrc_state_t next_cur;

    function automatic logic [4:0] on_ticks(input logic [1:0] code);
        unique case (code)
            2'h0: on_ticks = ON_TICKS_0;
            2'h1: on_ticks = ON_TICKS_1;
            2'h2: on_ticks = ON_TICKS_2;
            2'h3: on_ticks = ON_TICKS_3;
        endcase
    endfunction

    function automatic logic [4:0] off_ticks(input logic [1:0] code);
        unique case (code)
            2'h1: off_ticks = OFF_TICKS_1;
            2'h2: off_ticks = OFF_TICKS_2;
            2'h3: off_ticks = OFF_TICKS_3;
            2'h0: off_ticks = 5'h00;
        endcase
    endfunction

    function automatic logic [14:0] code_to_ua(input logic [6:0] code, input logic square);
        logic [31:0] sq;
        sq = 32'(code) * 32'(code) * 32'(DIM_FULL_UA);
        if (code == DIM_CODE_FULL) begin
            code_to_ua = DIM_FULL_UA;
        end else if (square) begin
            code_to_ua = 15'(sq / DIM_FULL_SQ);
        end else begin
            code_to_ua = 15'(code) * DIM_LIN_STEP_UA;
        end
    endfunction

    logic [NUM_SINKS-1:0][1:0] off_code;
    logic [6:0] rising;
    logic tick;
    logic en_wr;

    assign off_code[6] = cur.timing[SINK7_OFF_TIME_LSB +: 2];
    assign off_code[5] = cur.timing[SINK6_OFF_TIME_LSB +: 2];
    assign off_code[4] = cur.timing[SINK5_OFF_TIME_LSB +: 2];
    assign off_code[3] = sink_lower_off_i[7:6];
    assign off_code[2] = sink_lower_off_i[5:4];
    assign off_code[1] = sink_lower_off_i[3:2];
    assign off_code[0] = sink_lower_off_i[1:0];
    assign en_wr = wr_en_i && (addr_i == SINK_ENABLE_CTRL_OFFS);
    assign rising = en_wr ? (wdata_i[6:0] & ~cur.sink_enable) : 7'h00;
    assign tick = (cur.presc == PRESC_W'(TICK_CYCLES - 1));

    always_comb begin
        next_cur = cur;
        // Writes keep only defined bits, so reserved bits stay zero
        if (wr_en_i) begin
            unique case (addr_i)
                DARK_DIM_CURRENT_OFFS: next_cur.dark_dim_code = wdata_i[DARK_DIM_CODE_LSB +: 7];
                SINK_FADE_LAW_CTRL_OFFS: next_cur.sink_fade_law = wdata_i[SINK_FADE_LAW_LSB +: 2];
                SINK_ENABLE_CTRL_OFFS: next_cur.sink_enable = wdata_i[6:0];
                SINK_TIMING_UPPER_OFFS: next_cur.timing = wdata_i;
                default: ;
            endcase
        end
        // A write that starts sinks restarts the shared tick, so sinks enabled together blink in step
        if (rising != 7'h00) begin
            next_cur.presc = '0;
        end else if (tick) begin
            next_cur.presc = '0;
        end else begin
            next_cur.presc = PRESC_W'(cur.presc + 1'b1);
        end
        for (int i = 0; i < NUM_SINKS; i++) begin
            if (!cur.sink_enable[i] || rising[i] || off_code[i] == 2'h0) begin
                next_cur.phase[i] = PH_ON;
                next_cur.cnt[i] = '0;
            end else if (tick) begin
                next_cur.cnt[i] = TICK_CNT_W'(cur.cnt[i] + 1'b1);
                unique case (cur.phase[i])
                    PH_ON: begin
                        if (next_cur.cnt[i] >= on_ticks(cur.timing[SINK_ON_TIME_LSB +: 2])) begin
                            next_cur.phase[i] = PH_OFF;
                            next_cur.cnt[i] = '0;
                        end
                    end
                    PH_OFF: begin
                        if (next_cur.cnt[i] >= off_ticks(off_code[i])) begin
                            next_cur.phase[i] = PH_ON;
                            next_cur.cnt[i] = '0;
                        end
                    end
                    default: begin
                        next_cur.phase[i] = PH_ON;
                        next_cur.cnt[i] = '0;
                    end
                endcase
            end
            next_cur.sink_on[i] = next_cur.sink_enable[i] && (next_cur.phase[i] == PH_ON);
        end
        next_cur.dimmed = dim_timeout_i || force_dim_i;
        next_cur.bl_code = next_cur.dimmed ? cur.dark_dim_code : bright_code_i;
        next_cur.dim_ua = code_to_ua(cur.dark_dim_code, bl_square_law_i);
        next_cur.square_dac = (cur.sink_fade_law != LAW_LINEAR);
        next_cur.nonlin_time = (cur.sink_fade_law == LAW_CUBIC_A) || (cur.sink_fade_law == LAW_CUBIC_B);
        next_cur.cubic_alt = (cur.sink_fade_law == LAW_CUBIC_B);
        unique case (addr_i)
            DARK_DIM_CURRENT_OFFS: next_cur.rdata = {1'b0, cur.dark_dim_code} & DARK_DIM_MASK;
            SINK_FADE_LAW_CTRL_OFFS: next_cur.rdata = {6'h00, cur.sink_fade_law} & SINK_FADE_LAW_MASK;
            SINK_ENABLE_CTRL_OFFS: next_cur.rdata = {1'b0, cur.sink_enable} & SINK_ENABLE_MASK;
            SINK_TIMING_UPPER_OFFS: next_cur.rdata = cur.timing;
            default: next_cur.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cur <= '0;
            cur.dark_dim_code <= DARK_DIM_RESET;
            cur.sink_fade_law <= SINK_FADE_LAW_RESET;
            cur.sink_enable <= SINK_ENABLE_RESET;
            cur.timing <= SINK_TIMING_RESET;
            cur.phase <= '{default: PH_ON};
        end else begin
            cur <= next_cur;
        end
    end

    assign rdata_o = cur.rdata;
    assign bl_code_o = cur.bl_code;
    assign dim_current_ua_o = cur.dim_ua;
    assign dimmed_o = cur.dimmed;
    assign sink_on_o = cur.sink_on;
    assign sink_fade_law_o = cur.sink_fade_law;
    assign fade_square_dac_o = cur.square_dac;
    assign fade_nonlinear_time_o = cur.nonlin_time;
    assign fade_cubic_alt_o = cur.cubic_alt;

    // Checks
    sequence s_dim_req;
        dim_timeout_i || force_dim_i;
    endsequence

    property p_dim_select;
        @(posedge clock_i) disable iff (!resetn_i)
        s_dim_req ##1 1'b1 |-> (bl_code_o == $past(cur.dark_dim_code)) && dimmed_o;
    endproperty
    a_dim_select: assert property (p_dim_select) else $error("dim code not applied");

    property p_dim_write;
        @(posedge clock_i) disable iff (!resetn_i)
        wr_en_i && addr_i == DARK_DIM_CURRENT_OFFS |=> cur.dark_dim_code == $past(wdata_i[6:0]);
    endproperty
    a_dim_write: assert property (p_dim_write) else $error("dim code write lost");

    property p_full_current;
        @(posedge clock_i) disable iff (!resetn_i)
        cur.dark_dim_code == DIM_CODE_FULL ##1 $stable(cur.dark_dim_code) |-> dim_current_ua_o == DIM_FULL_UA;
    endproperty
    a_full_current: assert property (p_full_current) else $error("full code not 30 mA");

    property p_reserved_zero;
        @(posedge clock_i) disable iff (!resetn_i)
        addr_i == SINK_ENABLE_CTRL_OFFS || addr_i == DARK_DIM_CURRENT_OFFS |=> rdata_o[7] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit reads one");

    property p_law_reserved;
        @(posedge clock_i) disable iff (!resetn_i)
        addr_i == SINK_FADE_LAW_CTRL_OFFS |=> rdata_o == {6'h00, $past(cur.sink_fade_law)};
    endproperty
    a_law_reserved: assert property (p_law_reserved) else $error("fade law readback wrong");

    property p_law_decode;
        @(posedge clock_i) disable iff (!resetn_i)
        1'b1 |=> fade_square_dac_o == ($past(sink_fade_law_o) != LAW_LINEAR) &&
            fade_nonlinear_time_o == $past(sink_fade_law_o[1]) &&
            fade_cubic_alt_o == ($past(sink_fade_law_o) == LAW_CUBIC_B);
    endproperty
    a_law_decode: assert property (p_law_decode) else $error("fade law decode wrong");

    property p_disabled_off;
        @(posedge clock_i) disable iff (!resetn_i)
        (sink_on_o & ~cur.sink_enable) == 7'h00;
    endproperty
    a_disabled_off: assert property (p_disabled_off) else $error("disabled sink driven");

    property p_steady_on;
        @(posedge clock_i) disable iff (!resetn_i)
        cur.sink_enable[6] && off_code[6] == 2'h0 && !en_wr |=> sink_on_o[6];
    endproperty
    a_steady_on: assert property (p_steady_on) else $error("steady sink went dark");

    property p_on_len;
        @(posedge clock_i) disable iff (!resetn_i)
        $fell(sink_on_o[6]) && $past(cur.sink_enable[6]) && cur.sink_enable[6] |->
            $past(cur.cnt[6]) == 5'(on_ticks($past(cur.timing[7:6])) - 1'b1);
    endproperty
    a_on_len: assert property (p_on_len) else $error("on time length wrong");

    property p_off_len;
        @(posedge clock_i) disable iff (!resetn_i)
        $rose(sink_on_o[6]) && $past(cur.phase[6]) == PH_OFF && $past(off_code[6]) != 2'h0 |->
            $past(cur.cnt[6]) == 5'(off_ticks($past(off_code[6])) - 1'b1);
    endproperty
    a_off_len: assert property (p_off_len) else $error("off time length wrong");
endmodule

/* File: lsrc_host.sv */
// Host processor model driving the register access port
`timescale 1ns/100ps
module lsrc_host (
    // Clock
    input wire logic clock_i,
    // Register access port
    output logic wr_en_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    initial begin
        wr_en_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // All sink enables go in one write so their sequences start together
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock_i);
        wr_en_o = 1'b1;
        addr_o = addr;
        wdata_o = data;
        @(negedge clock_i);
        wr_en_o = 1'b0;
        // Released data lines must not look like a held value
        wdata_o = ~data;
    endtask
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clock_i);
        addr_o = addr;
        @(negedge clock_i);
        @(negedge clock_i);
        data = rdata_i;
    endtask
endmodule

/* File: tb.sv */
// Self-checking testbench for the LED sink control registers
`timescale 1ns/100ps
module tb;
    import lsrc_pkg::*;
    localparam logic [7:0] ADDRS [5] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12};
    localparam logic [7:0] MASKS [5] = '{8'h7f, 8'h03, 8'h7f, 8'hff, 8'h00};
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wr_en, dimmed_o, fade_square_dac_o, fade_nonlinear_time_o, fade_cubic_alt_o;
    logic dim_timeout_i = 1'b0, force_dim_i = 1'b0, bl_square_law_i = 1'b0;
    logic [7:0] addr, wdata, rdata, rd;
    logic [7:0] sink_lower_off_i = 8'h00;
    logic [6:0] bright_code_i = 7'h15, bl_code_o, sink_on_o;
    logic [14:0] dim_current_ua_o;
    logic [1:0] sink_fade_law_o;
    int err_count = 0;
    int total_checks = 0;
    always #5 clock_i = ~clock_i;
    // Short tick keeps the blink periods to a few dozen cycles
    lsrc_regs #(.TICK_CYCLES(4)) lsrc_regs_i (.clock_i(clock_i), .resetn_i(resetn_i), .wr_en_i(wr_en),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .dim_timeout_i(dim_timeout_i),
        .force_dim_i(force_dim_i), .bl_square_law_i(bl_square_law_i), .bright_code_i(bright_code_i),
        .bl_code_o(bl_code_o), .dim_current_ua_o(dim_current_ua_o), .dimmed_o(dimmed_o),
        .sink_lower_off_i(sink_lower_off_i), .sink_on_o(sink_on_o), .sink_fade_law_o(sink_fade_law_o),
        .fade_square_dac_o(fade_square_dac_o), .fade_nonlinear_time_o(fade_nonlinear_time_o),
        .fade_cubic_alt_o(fade_cubic_alt_o));
    lsrc_host lsrc_host_i (.clock_i(clock_i), .wr_en_o(wr_en), .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));
    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic t_regs();
        for (int i = 0; i < 5; i++) begin
            lsrc_host_i.read_reg(ADDRS[i], rd);
            check("reset value", rd, 8'h00);
        end
        for (int i = 0; i < 5; i++) begin
            lsrc_host_i.write_reg(ADDRS[i], 8'hff);
            lsrc_host_i.read_reg(ADDRS[i], rd);
            check("reserved bits", rd, MASKS[i]);
            lsrc_host_i.write_reg(ADDRS[i], 8'h00);
        end
    endtask
    task automatic t_law();
        for (int c = 0; c < 4; c++) begin
            lsrc_host_i.write_reg(8'h0f, {6'h3f, 2'(c)});
            repeat (2) @(negedge clock_i);
            check("fade law", sink_fade_law_o, 32'(c));
            check("square dac", fade_square_dac_o, 32'(c != 0));
            check("nonlinear time", fade_nonlinear_time_o, 32'(c >= 2));
            check("second cubic", fade_cubic_alt_o, 32'(c == 3));
        end
    endtask
    task automatic t_dim();
        for (int q = 0; q < 2; q++) begin
            bl_square_law_i = q[0];
            lsrc_host_i.write_reg(8'h0e, 8'hff);
            repeat (2) @(negedge clock_i);
            check("full dim current", dim_current_ua_o, 32'd30000);
            lsrc_host_i.write_reg(8'h0e, 8'h81);
            repeat (2) @(negedge clock_i);
            check("step dim current", dim_current_ua_o, q ? 32'd1 : 32'd236);
            lsrc_host_i.write_reg(8'h0e, 8'h00);
            repeat (2) @(negedge clock_i);
            check("zero dim current", dim_current_ua_o, 32'd0);
        end
        lsrc_host_i.write_reg(8'h0e, 8'h5a);
        for (int s = 0; s < 2; s++) begin
            @(negedge clock_i);
            if (s == 0) begin
                force_dim_i = 1'b1;
            end else begin
                dim_timeout_i = 1'b1;
            end
            @(negedge clock_i);
            check("dimmed", dimmed_o, 32'd1);
            check("dim code", bl_code_o, 32'h5a);
            force_dim_i = 1'b0;
            dim_timeout_i = 1'b0;
            @(negedge clock_i);
            check("undimmed", dimmed_o, 32'd0);
            check("bright code", bl_code_o, 32'h15);
        end
    endtask
    task automatic t_steady();
        lsrc_host_i.write_reg(8'h11, 8'hc0);
        lsrc_host_i.write_reg(8'h10, 8'h7f);
        check("all sinks on", sink_on_o, 32'h7f);
        repeat (150) @(negedge clock_i);
        check("sinks stay on", sink_on_o, 32'h7f);
        lsrc_host_i.write_reg(8'h10, 8'h00);
        check("all sinks off", sink_on_o, 32'h00);
    endtask
    task automatic measure(input int idx, input logic lvl, output int n);
        n = 0;
        while (sink_on_o[idx] === lvl) begin
            n++;
            if (n > 500) begin
                err_count++;
                $display("BAD sink level expected change seen none");
                print_verdict();
            end
            @(negedge clock_i);
        end
    endtask
    task automatic t_blink(input logic [7:0] tim, input logic [7:0] low, input logic [6:0] en,
                           input int idx, input int on_len, input int off_len);
        int n;
        lsrc_host_i.write_reg(8'h11, tim);
        sink_lower_off_i = low;
        lsrc_host_i.write_reg(8'h10, {1'b0, en});
        measure(idx, 1'b1, n);
        check("on time", n, on_len);
        measure(idx, 1'b0, n);
        check("off time", n, off_len);
        check("on again", sink_on_o[idx], 32'd1);
        lsrc_host_i.write_reg(8'h10, 8'h00);
        check("disabled", sink_on_o, 32'h00);
    endtask
    initial begin
        repeat (8) @(negedge clock_i);
        resetn_i = 1'b1;
        t_regs();
        t_law();
        t_dim();
        t_steady();
        t_blink(8'h50, 8'h00, 7'h40, 6, 24, 24);
        t_blink(8'h0c, 8'h00, 7'h20, 5, 8, 72);
        t_blink(8'h82, 8'h00, 7'h10, 4, 32, 48);
        t_blink(8'hc0, 8'h02, 7'h01, 0, 48, 48);
        print_verdict();
    end
endmodule
